// ### core/scan_dma_defines.svh
// Register offsets, field positions, reset values and sizes of the scan pointer DMA path
`ifndef SCAN_DMA_DEFINES_SVH
`define SCAN_DMA_DEFINES_SVH
// Register byte offsets on the APB side
`define OFS_CONV_CTL 8'h00
`define OFS_PTR_DATA 8'h04
`define OFS_XFER_CTL 8'h08
`define OFS_WORD_CNT 8'h0c
`define OFS_HOST_ADDR 8'h10
`define OFS_STATUS 8'h14
// Converter control fields
`define CTL_GO_BIT 0
`define CTL_SEL_LSB 11
`define CTL_SEL_MSB 13
`define CONV_CTL_RST 16'h0000
// Pointer select codes in the instruction field
`define PSEL_START 3'h0
`define PSEL_CUR 3'h1
`define PSEL_FINAL 3'h2
// Transfer control fields
`define XCTL_MODE_LSB 0
`define XCTL_MODE_MSB 1
`define XCTL_ERR_BIT 6
`define XCTL_DONE_BIT 7
// Sizes
`define WORD_W 16
`define PTR_W 8
`define FIFO_DEPTH 16
`define FIFO_AW 4
// Converter ready stays high while the level is below this
`define FIFO_HEADROOM 5'h0f
`endif

// ### core/scan_dma_pkg.sv
// Types shared by the scan pointer DMA path
`include "scan_dma_defines.svh"
package scan_dma_pkg;
  // Drain state, one bit changes on each step of the path
  typedef enum logic [1:0] {
    XS_IDLE = 2'h0,
    XS_HOST = 2'h1,
    XS_EXT = 2'h2
  } xfer_state_e;

  // Decoded data route
  typedef enum logic [1:0] {
    DM_OFF = 2'h0,
    DM_HOST = 2'h1,
    DM_EXT = 2'h2
  } dma_route_e;

  // Whole state of the top module
  typedef struct packed {
    logic [15:0] ctl;
    logic [`PTR_W-1:0] p_start;
    logic [`PTR_W-1:0] p_cur;
    logic [`PTR_W-1:0] p_final;
    logic scan_run;
    logic [1:0] mode;
    logic done;
    logic err;
    logic [15:0] wcount;
    logic [15:0] haddr;
    xfer_state_e st;
    logic [`WORD_W-1:0] word;
    logic hb_req;
    logic ext_stb;
    logic conv_rdy;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } core_s;

  // FIFO pointer state
  typedef struct packed {
    logic [`FIFO_AW:0] wr;
    logic [`FIFO_AW:0] rd;
  } fifo_s;
endpackage

// ### core/sample_fifo.sv
// Sample FIFO between the converter and the DMA drain
`timescale 1ns/100ps
`include "scan_dma_defines.svh"
module sample_fifo
  import scan_dma_pkg::*;
#(
  parameter int WIDTH = `WORD_W,
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int AW = `FIFO_AW
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [AW:0] level
);
  fifo_s f_q; // Pointers with one wrap bit each
  fifo_s f_d;
  logic [WIDTH-1:0] mem [DEPTH]; // Storage, no reset needed
  logic push;
  logic pop;

  // Wrap bits make a full buffer read as DEPTH rather than zero
  assign level = f_q.wr - f_q.rd;
  assign in_ready = (level < (AW+1)'(DEPTH));
  assign out_valid = (f_q.wr != f_q.rd);
  assign out_data = mem[f_q.rd[AW-1:0]];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Next pointers
  always_comb begin
    f_d = f_q;
    if (push) begin
      f_d.wr = f_q.wr + 1'b1;
    end
    if (pop) begin
      f_d.rd = f_q.rd + 1'b1;
    end
  end

  // Pointer registers
  always_ff @(posedge clk) begin
    if (rst) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[f_q.wr[AW-1:0]] <= in_data;
    end
  end
endmodule

// ### core/scan_pointer_dma_path.sv
// Channel-list scan pointers and DMA routing of converted words, APB register slave
`timescale 1ns/100ps
`include "scan_dma_defines.svh"

// Summary of operation
// [RULE1] Control bits 13..11 pick the accessed pointer
// [RULE2] Start pointer holds the scan's first address
// [RULE3] Current pointer drives the converter channel address
// [RULE4] Final pointer marks the last converted entry
// [RULE5] Start and final frozen while scanning
// [RULE6] Converted words move to memory by DMA
// [RULE7] Without external memory use host bus
// [RULE8] External memory allows either route
// [RULE9] External transfers leave host bus idle
// [RULE10] Samples go straight to external port
// [RULE11] External memory arbitrates its own ports
// [RULE12] Mode 00 off, 01/11 host, 10 external
// [RULE13] Current steps to final, then reloads start
// [RULE14] Word counter counts up to zero, done
// [RULE15] Memory error aborts, sets done and error
// [RULE16] External word held with strobe until acknowledged
module scan_pointer_dma_path
  import scan_dma_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conv_valid,
  input wire logic [`WORD_W-1:0] conv_data,
  output logic conv_ready,
  output logic [`PTR_W-1:0] chan_addr,
  input wire logic ext_present,
  output logic hb_req,
  output logic [15:0] hb_addr,
  output logic [`WORD_W-1:0] hb_data,
  input wire logic hb_ack,
  input wire logic hb_err,
  output logic ext_stb,
  output logic [`WORD_W-1:0] ext_data,
  input wire logic ext_ack,
  input wire logic ext_err
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  core_s s_q; // All registered state
  core_s s_d; // Next state
  logic push; // Converter word accepted
  logic fifo_in_ready; // FIFO room, also guards the push
  logic fifo_out_valid; // Word waiting to drain
  logic fifo_out_ready; // Drain takes a word
  logic [`WORD_W-1:0] fifo_out_data;
  logic [`FIFO_AW:0] fifo_level;
  dma_route_e route; // Decoded mode field
  logic [2:0] ptr_sel; // Instruction field of the control register
  logic wr_en; // Write takes effect this edge
  logic [`PTR_W-1:0] sel_ptr; // Pointer seen through the data register
  logic [15:0] wc_next; // Counter after one word

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Known register offset
  // Unmapped offsets answer with pslverr and read as zero
  function automatic logic reg_hit(input logic [7:0] a);
    return (a == `OFS_CONV_CTL) || (a == `OFS_PTR_DATA) || (a == `OFS_XFER_CTL) ||
           (a == `OFS_WORD_CNT) || (a == `OFS_HOST_ADDR) || (a == `OFS_STATUS);
  endfunction

  // Mode field decode, both bits set falls back to the host bus
  function automatic dma_route_e route_of(input logic [1:0] m);
    case (m)
      2'h0: return DM_OFF; // RULE12
      2'h2: return DM_EXT;
      default: return DM_HOST;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sample FIFO

  // Sixteen words absorb the wait states of a slow host memory
  sample_fifo #(
    .WIDTH(`WORD_W),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) sample_fifo_inst (
    .clk(clk),
    .rst(rst),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(conv_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Combinational helpers

  // Ready is registered, so one slot of headroom covers its lag
  assign push = conv_valid & s_q.conv_rdy & s_q.scan_run & fifo_in_ready;
  assign route = route_of(s_q.mode);
  assign ptr_sel = s_q.ctl[`CTL_SEL_MSB:`CTL_SEL_LSB]; // RULE1
  // Writes land at the access edge, when pready is already up
  assign wr_en = psel & penable & pwrite & s_q.pready & reg_hit(paddr);
  // Counter counts up from the negated length; zero ends the block
  assign wc_next = s_q.wcount + 16'h0001;
  // Drain only when a route is open and no done is pending
  assign fifo_out_ready = (s_q.st == XS_IDLE) && (route != DM_OFF) && !s_q.done; // RULE6

  // Pointer view selected by the instruction field
  always_comb begin
    case (ptr_sel)
      `PSEL_START: sel_ptr = s_q.p_start;
      `PSEL_CUR: sel_ptr = s_q.p_cur;
      `PSEL_FINAL: sel_ptr = s_q.p_final;
      default: sel_ptr = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d = s_q;
    // Every field except pready, pslverr and conv_rdy holds unless a branch below moves it
    // APB answers one cycle after setup
    s_d.pready = psel & ~penable;
    s_d.pslverr = 1'b0;
    s_d.conv_rdy = fifo_level < `FIFO_HEADROOM;
    // Read data and error are latched in the setup cycle
    // The status word is a snapshot; the level may move before it is used
    if (psel && !penable) begin
      s_d.pslverr = !reg_hit(paddr);
      case (paddr)
        `OFS_CONV_CTL: s_d.prdata = {16'h0000, s_q.ctl};
        `OFS_PTR_DATA: s_d.prdata = {24'h000000, sel_ptr};
        `OFS_XFER_CTL: s_d.prdata = {24'h000000, s_q.done, s_q.err, 4'h0, s_q.mode};
        `OFS_WORD_CNT: s_d.prdata = {16'h0000, s_q.wcount};
        `OFS_HOST_ADDR: s_d.prdata = {16'h0000, s_q.haddr};
        `OFS_STATUS: s_d.prdata = {16'h0000, fifo_level, s_q.st, s_q.scan_run, s_q.p_cur};
        default: s_d.prdata = 32'h00000000;
      endcase
    end
    // Software writes, applied before hardware events so sets win
    if (wr_en) begin
      case (paddr)
        `OFS_CONV_CTL: begin
          // Go bit is a strobe, not stored
          // A go bit during a running scan is ignored, the list is not restarted
          s_d.ctl = pwdata[15:0] & ~(16'h0001 << `CTL_GO_BIT);
          if (pwdata[`CTL_GO_BIT] && !s_q.scan_run) begin
            s_d.scan_run = 1'b1;
            s_d.p_cur = s_q.p_start; // RULE2
          end
        end
        `OFS_PTR_DATA: begin
          // Pointers only move by software between scans
          if (!s_q.scan_run) begin // RULE5
            case (ptr_sel)
              `PSEL_START: s_d.p_start = pwdata[`PTR_W-1:0]; // RULE2
              `PSEL_CUR: s_d.p_cur = pwdata[`PTR_W-1:0];
              `PSEL_FINAL: s_d.p_final = pwdata[`PTR_W-1:0]; // RULE4
              default: s_d.p_cur = s_q.p_cur;
            endcase
          end
        end
        `OFS_XFER_CTL: begin
          // A word already in flight finishes on the route it started on
          s_d.mode = pwdata[`XCTL_MODE_MSB:`XCTL_MODE_LSB];
          // Flags are cleared by writing zero, a one leaves them
          if (!pwdata[`XCTL_DONE_BIT]) begin
            s_d.done = 1'b0;
          end
          if (!pwdata[`XCTL_ERR_BIT]) begin
            s_d.err = 1'b0;
          end
        end
        `OFS_WORD_CNT: s_d.wcount = pwdata[15:0];
        `OFS_HOST_ADDR: s_d.haddr = pwdata[15:0];
        default: s_d.ctl = s_q.ctl;
      endcase
    end
    // Pointer step on each accepted conversion
    // Reload at the final entry ends the scan; a new go bit starts the next
    if (push) begin
      if (s_q.p_cur == s_q.p_final) begin // RULE4
        s_d.p_cur = s_q.p_start; // RULE13
        s_d.scan_run = 1'b0;
      end else begin
        s_d.p_cur = s_q.p_cur + 8'h01; // RULE13
      end
    end
    // Drain machine
    // One word in flight at a time; the idle cycle between words keeps
    // the next pop from meeting the answer to the last word
    case (s_q.st)
      XS_IDLE: begin
        if (fifo_out_valid && fifo_out_ready) begin
          s_d.word = fifo_out_data;
          if (route == DM_HOST) begin
            s_d.hb_req = 1'b1; // RULE7
            s_d.st = XS_HOST;
          end else if (ext_present) begin
            // Host bus stays quiet on this path
            s_d.ext_stb = 1'b1; // RULE8 RULE9 RULE10
            s_d.st = XS_EXT;
          end else begin
            // External route with nothing attached is an access error
            s_d.err = 1'b1; // RULE15
            s_d.done = 1'b1;
          end
        end
      end
      XS_HOST: begin
        if (hb_err) begin
          // Abort: the word is lost, software restarts from the flags
          s_d.hb_req = 1'b0;
          s_d.err = 1'b1; // RULE15
          s_d.done = 1'b1;
          s_d.st = XS_IDLE;
        end else if (hb_ack) begin
          // Address and counter step only on a clean answer
          s_d.hb_req = 1'b0;
          s_d.haddr = s_q.haddr + 16'h0001;
          s_d.wcount = wc_next; // RULE14
          if (wc_next == 16'h0000) begin
            s_d.done = 1'b1; // RULE14
          end
          s_d.st = XS_IDLE;
        end
      end
      XS_EXT: begin
        // Word and strobe stand until the far end answers
        if (ext_err) begin
          s_d.ext_stb = 1'b0;
          s_d.err = 1'b1; // RULE15
          s_d.done = 1'b1;
          s_d.st = XS_IDLE;
        end else if (ext_ack) begin
          s_d.ext_stb = 1'b0; // RULE16
          s_d.st = XS_IDLE;
        end
      end
      default: s_d.st = XS_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  // Synchronous reset clears every field: mode off, flags and pointers zero

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register
  // Nothing here is combinational, so the far side never sees a glitch

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign conv_ready = s_q.conv_rdy;
  assign chan_addr = s_q.p_cur; // RULE3
  assign hb_req = s_q.hb_req;
  assign hb_addr = s_q.haddr;
  assign hb_data = s_q.word;
  assign ext_stb = s_q.ext_stb;
  assign ext_data = s_q.word;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Pointer sequencing and the scan window
  chk_ptr_wrap: assert property (push && s_q.p_cur == s_q.p_final |=> s_q.p_cur == $past(s_q.p_start)) // RULE13
    else $error("current pointer did not reload from start");
  chk_ptr_step: assert property (push && s_q.p_cur != s_q.p_final |=> s_q.p_cur == $past(s_q.p_cur) + 8'h01) // RULE13
    else $error("current pointer did not step by one");
  chk_start_hold: assert property (s_q.scan_run |=> $stable(s_q.p_start) && $stable(s_q.p_final)) // RULE5
    else $error("start or final pointer moved during scan");
  // Transfer paths and flags
  chk_ext_quiet: assert property (s_q.st == XS_EXT |-> !s_q.hb_req) // RULE9
    else $error("host bus request during external transfer");
  chk_ext_hold: assert property (s_q.ext_stb && !ext_ack && !ext_err |=> s_q.ext_stb && $stable(ext_data)) // RULE16
    else $error("external word dropped before acknowledge");
  chk_wc_done: assert property (s_q.hb_req && hb_ack && !hb_err && s_q.wcount == 16'hffff |=> s_q.done) // RULE14
    else $error("word counter reached zero without done");
  chk_err_done: assert property ((s_q.hb_req && hb_err) || (s_q.ext_stb && ext_err) |=> s_q.done && s_q.err) // RULE15
    else $error("memory error did not set done and error");
  chk_route_off: assert property (s_q.mode == 2'h0 && s_q.st == XS_IDLE |=> !s_q.hb_req && !s_q.ext_stb) // RULE12
    else $error("transfer started with DMA disabled");
  chk_ext_attach: assert property ($rose(s_q.ext_stb) |-> $past(ext_present) && $past(s_q.mode) == 2'h2) // RULE7
    else $error("external transfer without attached memory");

  // The data register shows the current pointer when the instruction field picks it
  chk_ptr_view: assert property (psel && !penable && paddr == `OFS_PTR_DATA && ptr_sel == `PSEL_CUR // RULE1 RULE3
    |=> prdata == {24'h000000, $past(s_q.p_cur)})
    else $error("current pointer not shown through the data register");
  // Go bit starts the scan at the start pointer
  chk_go_start: assert property (wr_en && paddr == `OFS_CONV_CTL && pwdata[`CTL_GO_BIT] && !s_q.scan_run // RULE2
    |=> s_q.scan_run && s_q.p_cur == $past(s_q.p_start))
    else $error("scan did not start at the start pointer");
  // The last entry of the list ends the scan
  chk_scan_end: assert property (push && s_q.p_cur == s_q.p_final |=> !s_q.scan_run) // RULE13
    else $error("scan still running after the final entry");
  // Registered ready may lag by a cycle, the headroom slot must cover it
  chk_rdy_room: assert property (s_q.conv_rdy |-> fifo_in_ready) // RULE6
    else $error("converter ready while the buffer is full");
  // Counter and address step together on each clean host answer
  chk_host_step: assert property (s_q.hb_req && hb_ack && !hb_err // RULE14
    |=> s_q.wcount == $past(s_q.wcount) + 16'h0001 && hb_addr == $past(s_q.haddr) + 16'h0001)
    else $error("host counter or address did not step");
  // A pending done flag stops the drain
  chk_done_stop: assert property (s_q.done && s_q.st == XS_IDLE |=> s_q.st == XS_IDLE) // RULE14 RULE15
    else $error("new word taken while done is pending");
  // Host requests only start on a host route
  chk_host_route: assert property ($rose(s_q.hb_req) |-> $past(route) == DM_HOST) // RULE7 RULE12
    else $error("host request without a host route");
  // The external port carries the word that left the buffer
  chk_ext_word: assert property ($rose(s_q.ext_stb) |-> ext_data == $past(fifo_out_data)) // RULE10
    else $error("external word differs from the buffered sample");

  // Main scenarios
  cov_scan_wrap: cover property (push && s_q.p_cur == s_q.p_final);
  cov_host_done: cover property (s_q.hb_req && hb_ack && s_q.wcount == 16'hffff);
  cov_ext_word: cover property (s_q.ext_stb && ext_ack);
  cov_host_fault: cover property (s_q.hb_req && hb_err);
  cov_ext_fault: cover property (s_q.ext_stb && ext_err);
endmodule

// ### testbench/mem_partner.sv
// Behavioural host memory and external dual-port memory facing the DMA path
`timescale 1ns/100ps
module mem_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] lag,
  input wire logic fail,
  input wire logic hb_req,
  input wire logic [15:0] hb_addr,
  input wire logic [15:0] hb_data,
  output logic hb_ack,
  output logic hb_err,
  input wire logic ext_stb,
  input wire logic [15:0] ext_data,
  output logic ext_ack,
  output logic ext_err
);
  logic [3:0] hw_q; // Host wait count
  logic [3:0] ew_q; // External wait count
  logic [15:0] hd_log[$]; // Words taken on the host bus
  logic [15:0] ha_log[$]; // Their word addresses
  logic [15:0] ed_log[$]; // Words taken on the external port

  // Answer lines are quiet before the first reset edge
  initial {hb_ack, hb_err, ext_ack, ext_err} = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Host side: answers after lag cycles; an answer stands one cycle only
  always @(posedge clk) begin
    if (rst || hb_ack || hb_err) begin
      hb_ack <= 1'b0;
      hb_err <= 1'b0;
      hw_q <= 4'h0;
    end else if (hb_req && hw_q != lag) begin
      hw_q <= hw_q + 4'h1; // Slow memory, request must hold meanwhile
    end else if (hb_req) begin
      hb_ack <= !fail;
      hb_err <= fail; // Bus error only when the bench commands it
      if (!fail) begin
        hd_log.push_back(hb_data);
        ha_log.push_back(hb_addr);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External side: its own process, so host traffic never disturbs it
  always @(posedge clk) begin
    if (rst || ext_ack || ext_err) begin
      ext_ack <= 1'b0;
      ext_err <= 1'b0;
      ew_q <= 4'h0;
    end else if (ext_stb && ew_q != lag) begin
      ew_q <= ew_q + 4'h1;
    end else if (ext_stb) begin
      ext_ack <= !fail;
      ext_err <= fail; // Port error only when the bench commands it
      if (!fail) begin
        ed_log.push_back(ext_data);
      end
    end
  end
endmodule

// ### testbench/scan_pointer_dma_path_test.sv
// Self-checking bench for the scan pointer DMA path
`timescale 1ns/100ps
`include "scan_dma_defines.svh"
module scan_pointer_dma_path_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, rerr, conv_ready, hb_req, hb_ack, hb_err, ext_stb, ext_ack, ext_err;
  logic conv_valid = 1'b0, ext_present = 1'b0, fail = 1'b0;
  logic [15:0] conv_data = 16'h0, hb_addr, hb_data, ext_data;
  logic [7:0] chan_addr;
  logic [3:0] lag = 4'h0; // Partner answer delay
  int num_errors = 0, n_compared = 0;
  int hb_busy = 0; // Host requests seen while external memory is attached

  always #4 clk = ~clk; // 125 MHz

  scan_pointer_dma_path scan_pointer_dma_path_inst (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_valid(conv_valid), .conv_data(conv_data),
    .conv_ready(conv_ready), .chan_addr(chan_addr), .ext_present(ext_present), .hb_req(hb_req),
    .hb_addr(hb_addr), .hb_data(hb_data), .hb_ack(hb_ack), .hb_err(hb_err), .ext_stb(ext_stb),
    .ext_data(ext_data), .ext_ack(ext_ack), .ext_err(ext_err));
  mem_partner mem_partner_inst (.clk(clk), .rst(rst), .lag(lag), .fail(fail), .hb_req(hb_req),
    .hb_addr(hb_addr), .hb_data(hb_data), .hb_ack(hb_ack), .hb_err(hb_err), .ext_stb(ext_stb),
    .ext_data(ext_data), .ext_ack(ext_ack), .ext_err(ext_err));

  // Any host request while ext_present is high is counted
  always @(posedge clk) begin
    if (ext_present && hb_req === 1'b1) hb_busy++;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (num_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic stall();
    num_errors++;
    $display("Error at %0t: wait timed out", $time);
    close_out();
  endtask

  // One APB transfer; the idle edge first keeps psel from two writes in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Request stands until pready is sampled high at a rising edge
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (k == 20) stall();
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    check(rdata, e);
  endtask

  // Poll until the transfer done flag shows
  task automatic wait_done();
    int k;
    for (k = 0; k < 100; k++) begin
      rd(`OFS_XFER_CTL);
      if (rdata[`XCTL_DONE_BIT] === 1'b1) break;
    end
    if (k == 100) stall();
  endtask

  // Three samples over the list 2..4; the third wraps the pointer and ends the scan
  task automatic feed(input logic [15:0] base);
    int i, k;
    logic [7:0] exp;
    exp = 8'h02;
    @(negedge clk);
    check(32'(chan_addr), 32'(exp));
    for (i = 0; i < 3; i++) begin
      @(posedge clk);
      conv_valid <= 1'b1;
      conv_data <= base + 16'(i);
      for (k = 0; k < 50; k++) begin
        @(negedge clk);
        if (conv_ready === 1'b1) break;
      end
      if (k == 50) stall();
      @(posedge clk);
      conv_valid <= 1'b0;
      exp = (exp == 8'h04) ? 8'h02 : exp + 8'h01;
      @(negedge clk);
      check(32'(chan_addr), 32'(exp));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic s_reset();
    rdc(`OFS_XFER_CTL, 32'h0);
    check(32'(conv_ready), 32'h1);
    rdc(`OFS_WORD_CNT, 32'h0);
    rd(8'h18);
    check(32'(rerr), 32'h1);
    check(rdata, 32'h0);
  endtask

  // Program the list bounds, then try to move the final one mid-scan
  task automatic s_scan();
    wr(`OFS_CONV_CTL, 32'h0000);
    wr(`OFS_PTR_DATA, 32'h0002);
    wr(`OFS_CONV_CTL, 32'h1000);
    wr(`OFS_PTR_DATA, 32'h0004);
    wr(`OFS_CONV_CTL, 32'h0000);
    rdc(`OFS_PTR_DATA, 32'h0002);
    wr(`OFS_CONV_CTL, 32'h1001);
    wr(`OFS_PTR_DATA, 32'h0009);
    rdc(`OFS_PTR_DATA, 32'h0004);
    feed(16'h0a00);
    @(posedge clk);
    conv_valid <= 1'b1; // Offered after the scan, must be ignored
    repeat (3) @(posedge clk);
    conv_valid <= 1'b0;
    @(negedge clk);
    check(32'(chan_addr), 32'h2);
    wr(`OFS_CONV_CTL, 32'h0800);
    rdc(`OFS_PTR_DATA, 32'h0002);
    rd(`OFS_STATUS);
    check(32'(rdata[8:0]), 32'h002);
    check(32'(mem_partner_inst.hd_log.size() + mem_partner_inst.ed_log.size()), 32'h0);
  endtask

  // Host route with a slow memory, modes 01 then 11
  task automatic s_host();
    int i;
    lag <= 4'h2;
    wr(`OFS_WORD_CNT, 32'hfffd);
    wr(`OFS_HOST_ADDR, 32'h0100);
    wr(`OFS_XFER_CTL, 32'h0001);
    wait_done();
    for (i = 0; i < 3; i++) begin
      check(32'(mem_partner_inst.hd_log[i]), 32'h0a00 + 32'(i));
      check(32'(mem_partner_inst.ha_log[i]), 32'h0100 + 32'(i));
    end
    rdc(`OFS_WORD_CNT, 32'h0);
    rdc(`OFS_XFER_CTL, 32'h0081);
    wr(`OFS_XFER_CTL, 32'h0003);
    wr(`OFS_WORD_CNT, 32'hffff);
    wr(`OFS_CONV_CTL, 32'h0001);
    feed(16'h0b00);
    wait_done();
    check(32'(mem_partner_inst.hd_log.size()), 32'h4);
    check(32'(mem_partner_inst.ha_log[3]), 32'h0103);
    check(32'(mem_partner_inst.ed_log.size()), 32'h0);
  endtask

  // External route drains the two words left; host bus stays idle
  task automatic s_ext();
    int k;
    ext_present <= 1'b1;
    lag <= 4'h5;
    wr(`OFS_XFER_CTL, 32'h0002);
    for (k = 0; k < 300 && mem_partner_inst.ed_log.size() < 2; k++) @(posedge clk);
    if (k == 300) stall();
    check(32'(mem_partner_inst.ed_log[0]), 32'h0b01);
    check(32'(mem_partner_inst.ed_log[1]), 32'h0b02);
    check(32'(hb_busy), 32'h0);
    @(posedge clk);
    ext_present <= 1'b0;
  endtask

  // Missing memory on the port, then a host bus error
  task automatic s_fault();
    wr(`OFS_CONV_CTL, 32'h0001);
    feed(16'h0c00);
    wait_done();
    rdc(`OFS_XFER_CTL, 32'h00c2);
    check(32'(mem_partner_inst.ed_log.size()), 32'h2);
    fail <= 1'b1;
    wr(`OFS_XFER_CTL, 32'h0001);
    wait_done();
    rdc(`OFS_XFER_CTL, 32'h00c1);
    check(32'(mem_partner_inst.hd_log.size()), 32'h4);
    // Port error on the last buffered word
    ext_present <= 1'b1;
    wr(`OFS_XFER_CTL, 32'h0002);
    wait_done();
    rdc(`OFS_XFER_CTL, 32'h00c2);
    check(32'(mem_partner_inst.ed_log.size()), 32'h2);
    check(32'(hb_busy), 32'h0);
    @(posedge clk);
    fail <= 1'b0;
    ext_present <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    s_reset();
    s_scan();
    s_host();
    s_ext();
    s_fault();
    close_out();
  end
endmodule
